// File: rtl/hcv_defs.svh
`ifndef HCV_DEFS_SVH
`define HCV_DEFS_SVH

`define HCV_MCLK_PERIOD_NS 50
`define HCV_LINK_PERIOD_NS 400
`define HCV_LINK_DIV (`HCV_LINK_PERIOD_NS / `HCV_MCLK_PERIOD_NS)
`define HCV_CODEC_ADDR 4'h0
`define HCV_CMD_BITS 6'h20
`define HCV_RSP_BITS 6'h21

`define HCV_VERB_SET_FMT 4'h2
`define HCV_VERB_SET_AMP 4'h3
`define HCV_VERB_GET_FMT 4'hA
`define HCV_VERB_GET_AMP 4'hB
`define HCV_VERB_GET_PWR 12'hF05
`define HCV_VERB_SET_PWR 12'h705
`define HCV_VERB_GET_STRM 12'hF06
`define HCV_VERB_SET_STRM 12'h706

`define HCV_NID_AFG 8'h01
`define HCV_NID_DAC_FIRST 8'h03
`define HCV_NID_SPDIF 8'h07
`define HCV_NID_ADC 8'h08
`define HCV_NID_MIX_MIC 8'h14
`define HCV_NID_MIX_ST 8'h15
`define HCV_NID_MIX_FIRST 8'h16
`define HCV_NID_MIX_LAST 8'h1B
`define HCV_NID_MIX_LINE 8'h1C
`define HCV_NID_TONE 8'h23

`define HCV_AMP_ADC 5'h05
`define HCV_AMP_MIC 5'h06
`define HCV_AMP_ST_IN 5'h07
`define HCV_AMP_ST_OUT 5'h09
`define HCV_AMP_MIX 5'h0A
`define HCV_AMP_LINE 5'h10
`define HCV_AMP_TONE 5'h11
`define HCV_AMP_SLOTS 36
`define HCV_ST_IN_COUNT 4'h2
`define HCV_CONV_COUNT 6

`define HCV_AMP_OUT_BIT 15
`define HCV_AMP_IN_BIT 14
`define HCV_AMP_LEFT_BIT 13
`define HCV_AMP_RIGHT_BIT 12
`define HCV_AMP_MUTE_ONLY 8'h80
`define HCV_AMP_FULL 8'hFF
`define HCV_AMP_RST 8'h80
`define HCV_FMT_RSVD_MASK 16'h0080
`define HCV_FMT_DIV_MASK 16'h0700
`define HCV_FMT_RST 16'h0011
`define HCV_STRM_RST 8'h00
`define HCV_PWR_RST 2'h0

`define HCV_REG_CMD 2'h0
`define HCV_REG_RSP 2'h1
`define HCV_REG_STAT 2'h2
`define HCV_STAT_BUSY_BIT 0
`define HCV_STAT_DONE_BIT 1

`endif

// File: rtl/hcv_pkg.sv
package hcv_pkg;
  typedef logic [31:0] hcv_word_t;
  typedef logic [1:0] hcv_pwr_t;
  typedef enum {HCV_C_IDLE, HCV_C_CMD, HCV_C_EXEC, HCV_C_RSP} hcv_codec_state_e;
  typedef enum {HCV_H_IDLE, HCV_H_SYNC, HCV_H_SEND, HCV_H_WAIT, HCV_H_RECV} hcv_host_state_e;
endpackage

// File: rtl/hcv_link_if.sv
`timescale 1ns/1ps
interface hcv_link_if;
  logic bitClk;
  logic sync;
  logic sdo;
  logic sdi;
  modport host
  (
    output bitClk,
    output sync,
    output sdo,
    input sdi
  );
  modport codec
  (
    input bitClk,
    input sync,
    input sdo,
    output sdi
  );
endinterface

// File: rtl/hcv_codec.sv
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "hcv_defs.svh"
// Notes on behaviour
// - Get-gain payload bit 15 picks output amplifier.
// - Get-gain payload bit 13 picks left channel.
// - Index 3:0 used only on multi-input widgets.
// - Playback converters report output mute only.
// - Capture converter reports input mute and gain.
// - Mixers 14h, 1Ch report input mute only.
// - Stereo mixer keeps per-index input and output amps.
// - Mixers 16h-1Bh report input mute only.
// - Tone generator keeps output mute and gain.
// - Unsupported get answers all zeros.
// - Set-gain bits 15:12 pick amplifiers updated.
// - Set-gain index 11:8 used only on mixer inputs.
// - Set-gain bit 7 mute, bits 6:0 gain.
// - Format bit 15 type, bit 14 base rate.
// - Format 13:11 multiplier, 10:8 divisor.
// - Capture format divisor always reads zero.
// - Format 6:4 sample width code.
// - Format 3:0 channels minus one; bit 7 zero.
// - Power read shows requested and actual state.
// - Set-power payload 1:0 sets function group power.
// - Stream read: stream 7:4, channel 3:0.
// - Set stream puts stream in payload 7:4.
// - Stereo converter uses channels n and n+1.
module hcv_codec
(
  input wire logic mclk,
  input wire logic nrst,
  hcv_link_if.codec link,
  output hcv_pkg::hcv_pwr_t powerState,
  output logic [3:0] captureStream,
  output logic [3:0] captureLeftChan,
  output logic [3:0] captureRightChan
);
  import hcv_pkg::*;

  logic [2:0] pinS0;
  logic [2:0] pinS1;
  logic [2:0] pinS2;
  logic [2:0] pinLvl_r;
  logic clkPrev_r;
  logic linkRise;
  hcv_codec_state_e state_r;
  logic [5:0] bitCnt_r;
  hcv_word_t cmd_r;
  logic [32:0] rspSh_r;
  logic sdiOut_r;
  logic [7:0] amp_r [0:`HCV_AMP_SLOTS-1];
  logic [15:0] fmt_r [0:`HCV_CONV_COUNT-1];
  logic [7:0] strm_r [0:`HCV_CONV_COUNT-1];
  logic [7:0] nid;
  logic [3:0] verb4;
  logic [11:0] verb12;
  logic [2:0] convIdx;
  logic isConv;
  logic execNow;
  logic [6:0] getSlot;
  logic [6:0] setSlot [0:3];
  hcv_word_t rspWord;

  // Returns {hit, amplifier, right}; amplifier pairs hold left then right.
  function automatic logic [6:0] ampSlot(input logic [7:0] id, input logic isOut, input logic isLeft,
                                         input logic [3:0] idx);
    logic ok;
    logic [4:0] amp;
    ok = 1'b0;
    amp = 5'h00;
    if (isOut)
    begin
      if (id >= `HCV_NID_DAC_FIRST && id <= `HCV_NID_SPDIF)
      begin
        ok = 1'b1;
        amp = 5'(id - `HCV_NID_DAC_FIRST);
      end
      else if (id == `HCV_NID_MIX_ST)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_ST_OUT;
      end
      else if (id == `HCV_NID_TONE)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_TONE;
      end
    end
    else
    begin
      if (id == `HCV_NID_ADC)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_ADC;
      end
      else if (id == `HCV_NID_MIX_MIC)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_MIC;
      end
      else if (id == `HCV_NID_MIX_ST && idx < `HCV_ST_IN_COUNT)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_ST_IN + 5'(idx);
      end
      else if (id >= `HCV_NID_MIX_FIRST && id <= `HCV_NID_MIX_LAST)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_MIX + 5'(id - `HCV_NID_MIX_FIRST);
      end
      else if (id == `HCV_NID_MIX_LINE)
      begin
        ok = 1'b1;
        amp = `HCV_AMP_LINE;
      end
    end
    return {ok, amp, ~isLeft};
  endfunction

  // Only the capture converter, the stereo mixer and the tone generator have gain steps.
  function automatic logic [7:0] ampMask(input logic [7:0] id);
    if (id == `HCV_NID_ADC || id == `HCV_NID_MIX_ST || id == `HCV_NID_TONE)
      return `HCV_AMP_FULL;
    return `HCV_AMP_MUTE_ONLY;
  endfunction

  function automatic logic [15:0] fmtClean(input logic [7:0] id, input logic [15:0] v);
    logic [15:0] r;
    r = v & ~`HCV_FMT_RSVD_MASK;
    if (id == `HCV_NID_ADC)
      r = r & ~`HCV_FMT_DIV_MASK;
    return r;
  endfunction

  // Sync and data pins share one filter so their samples line up with the clock edge.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pinS0 <= 3'h0;
      pinS1 <= 3'h0;
      pinS2 <= 3'h0;
    end
    else
    begin
      pinS0 <= {link.sdo, link.sync, link.bitClk};
      pinS1 <= pinS0;
      pinS2 <= pinS1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      pinLvl_r <= 3'h0;
      clkPrev_r <= 1'b0;
    end
    else
    begin
      pinLvl_r <= (pinS1 & pinS2) | (pinLvl_r & (pinS1 | pinS2));
      clkPrev_r <= pinLvl_r[0];
    end
  end

  assign linkRise = pinLvl_r[0] & ~clkPrev_r;
  assign nid = cmd_r[27:20];
  assign verb4 = cmd_r[19:16];
  assign verb12 = cmd_r[19:8];
  assign isConv = nid >= `HCV_NID_DAC_FIRST && nid <= `HCV_NID_ADC;
  assign convIdx = 3'(nid - `HCV_NID_DAC_FIRST);
  assign execNow = state_r == HCV_C_EXEC && cmd_r[31:28] == `HCV_CODEC_ADDR;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r <= HCV_C_IDLE;
      bitCnt_r <= 6'h00;
      cmd_r <= '0;
      rspSh_r <= '0;
      sdiOut_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        HCV_C_IDLE:
          if (linkRise && pinLvl_r[1])
          begin
            state_r <= HCV_C_CMD;
            bitCnt_r <= 6'h00;
          end
        HCV_C_CMD:
          if (linkRise)
          begin
            cmd_r <= {cmd_r[30:0], pinLvl_r[2]};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (bitCnt_r == `HCV_CMD_BITS - 6'h01)
              state_r <= HCV_C_EXEC;
          end
        HCV_C_EXEC:
        begin
          bitCnt_r <= 6'h00;
          rspSh_r <= {1'b1, rspWord};
          state_r <= execNow ? HCV_C_RSP : HCV_C_IDLE;
        end
        HCV_C_RSP:
          if (linkRise)
          begin
            sdiOut_r <= bitCnt_r != `HCV_RSP_BITS && rspSh_r[32];
            rspSh_r <= {rspSh_r[31:0], 1'b0};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (bitCnt_r == `HCV_RSP_BITS)
              state_r <= HCV_C_IDLE;
          end
      endcase
    end
  end

  assign link.sdi = sdiOut_r;

  always_comb
  begin
    getSlot = ampSlot(nid, cmd_r[`HCV_AMP_OUT_BIT], cmd_r[`HCV_AMP_LEFT_BIT], cmd_r[3:0]);
    rspWord = '0;
    if (verb4 == `HCV_VERB_GET_AMP && getSlot[6])
      rspWord = {24'h0, amp_r[getSlot[5:0]] & ampMask(nid)};
    else if (verb4 == `HCV_VERB_GET_FMT && isConv)
      rspWord = {16'h0, fmtClean(nid, fmt_r[convIdx])};
    else if (verb12 == `HCV_VERB_GET_PWR && nid == `HCV_NID_AFG)
      rspWord = {26'h0, powerState, 2'h0, powerState};
    else if (verb12 == `HCV_VERB_GET_STRM && isConv)
      rspWord = {24'h0, strm_r[convIdx]};
  end

  always_comb
  begin
    for (int k = 0; k < 4; k++)
      setSlot[k] = ampSlot(nid, k[1], k[0], cmd_r[11:8]);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `HCV_AMP_SLOTS; i++)
        amp_r[i] <= `HCV_AMP_RST;
    end
    else if (execNow && verb4 == `HCV_VERB_SET_AMP)
    begin
      for (int k = 0; k < 4; k++)
        if (cmd_r[k[1] ? `HCV_AMP_OUT_BIT : `HCV_AMP_IN_BIT] &&
            cmd_r[k[0] ? `HCV_AMP_LEFT_BIT : `HCV_AMP_RIGHT_BIT] && setSlot[k][6])
          amp_r[setSlot[k][5:0]] <= cmd_r[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < `HCV_CONV_COUNT; i++)
      begin
        fmt_r[i] <= `HCV_FMT_RST;
        strm_r[i] <= `HCV_STRM_RST;
      end
    end
    else if (execNow && isConv)
    begin
      if (verb4 == `HCV_VERB_SET_FMT)
        fmt_r[convIdx] <= fmtClean(nid, cmd_r[15:0]);
      else if (verb12 == `HCV_VERB_SET_STRM)
        strm_r[convIdx] <= cmd_r[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      powerState <= `HCV_PWR_RST;
    else if (execNow && verb12 == `HCV_VERB_SET_PWR && nid == `HCV_NID_AFG)
      powerState <= cmd_r[1:0];
  end

  // The capture slot assignment is exported so the sample path can pick its two channels.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      captureStream <= 4'h0;
      captureLeftChan <= 4'h0;
      captureRightChan <= 4'h0;
    end
    else
    begin
      captureStream <= strm_r[3'(`HCV_NID_ADC - `HCV_NID_DAC_FIRST)][7:4];
      captureLeftChan <= strm_r[3'(`HCV_NID_ADC - `HCV_NID_DAC_FIRST)][3:0];
      captureRightChan <= strm_r[3'(`HCV_NID_ADC - `HCV_NID_DAC_FIRST)][3:0] + 4'h1;
    end
  end
endmodule

// File: rtl/hcv_host.sv
`timescale 1ns/1ps
`include "hcv_defs.svh"
module hcv_host
(
  input wire logic mclk,
  input wire logic nrst,
  hcv_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire hcv_pkg::hcv_word_t wb_dat_i,
  output hcv_pkg::hcv_word_t wb_dat_o,
  output logic wb_ack_o
);
  import hcv_pkg::*;

  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic bitClk_r;
  logic sync_r;
  logic sdo_r;
  logic sdiS0;
  logic sdiS1;
  logic sdiS2;
  logic sdiLvl_r;
  logic fallNow;
  logic sampleNow;
  hcv_host_state_e state_r;
  logic [5:0] bitCnt_r;
  hcv_word_t cmd_r;
  hcv_word_t sendSh_r;
  hcv_word_t rsp_r;
  hcv_word_t rspSh_r;
  logic go_r;
  logic done_r;
  logic busy;
  logic wbReq;
  logic wbWrite;
  logic finish;

  // The bit clock runs free from the divider; commands are shifted on its falling edge.
  assign div_nxt = (div_r == 3'(`HCV_LINK_DIV - 1)) ? 3'h0 : div_r + 3'h1;
  assign fallNow = div_r == 3'(`HCV_LINK_DIV / 2 - 1);
  // Late enough in the period to see the codec's answer through both synchronisers.
  assign sampleNow = fallNow;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      // Parked one step before the wrap so the first high phase after reset is a full one.
      div_r <= 3'(`HCV_LINK_DIV - 1);
      bitClk_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      bitClk_r <= div_nxt < 3'(`HCV_LINK_DIV / 2);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sdiS0 <= 1'b0;
      sdiS1 <= 1'b0;
      sdiS2 <= 1'b0;
      sdiLvl_r <= 1'b0;
    end
    else
    begin
      sdiS0 <= link.sdi;
      sdiS1 <= sdiS0;
      sdiS2 <= sdiS1;
      sdiLvl_r <= (sdiS1 == sdiS2) ? sdiS2 : sdiLvl_r;
    end
  end

  assign busy = go_r || state_r != HCV_H_IDLE;
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge at which the master samples the acknowledge, not earlier.
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign finish = state_r == HCV_H_RECV && sampleNow && bitCnt_r == `HCV_CMD_BITS - 6'h01;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      wb_dat_o <= '0;
      if (wbReq && !wb_we_i)
        unique case (wb_adr_i[3:2])
          `HCV_REG_CMD: wb_dat_o <= cmd_r;
          `HCV_REG_RSP: wb_dat_o <= rsp_r;
          `HCV_REG_STAT: wb_dat_o <= {30'h0, done_r, busy};
          default: wb_dat_o <= '0;
        endcase
    end
  end

  // A command write while busy is dropped so the frame in flight stays intact.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cmd_r <= '0;
      go_r <= 1'b0;
    end
    else if (wbWrite && wb_adr_i[3:2] == `HCV_REG_CMD && !busy)
    begin
      for (int b = 0; b < 4; b++)
        if (wb_sel_i[b])
          cmd_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      go_r <= 1'b1;
    end
    else if (state_r == HCV_H_IDLE && fallNow)
      go_r <= 1'b0;
  end

  // A finishing answer wins over a clear in the same cycle.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      done_r <= 1'b0;
    else if (finish)
      done_r <= 1'b1;
    else if (wbWrite && wb_adr_i[3:2] == `HCV_REG_STAT && wb_sel_i[0] && wb_dat_i[`HCV_STAT_DONE_BIT])
      done_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state_r <= HCV_H_IDLE;
      bitCnt_r <= 6'h00;
      sync_r <= 1'b0;
      sdo_r <= 1'b0;
      sendSh_r <= '0;
      rspSh_r <= '0;
      rsp_r <= '0;
    end
    else
    begin
      unique case (state_r)
        HCV_H_IDLE:
          if (go_r && fallNow)
          begin
            sync_r <= 1'b1;
            sendSh_r <= cmd_r;
            bitCnt_r <= 6'h00;
            state_r <= HCV_H_SEND;
          end
        HCV_H_SEND:
          if (fallNow)
          begin
            sync_r <= 1'b0;
            sdo_r <= bitCnt_r != `HCV_CMD_BITS && sendSh_r[31];
            sendSh_r <= {sendSh_r[30:0], 1'b0};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (bitCnt_r == `HCV_CMD_BITS)
              state_r <= HCV_H_WAIT;
          end
        HCV_H_WAIT:
          if (sampleNow && sdiLvl_r)
          begin
            bitCnt_r <= 6'h00;
            state_r <= HCV_H_RECV;
          end
        HCV_H_RECV:
          if (sampleNow)
          begin
            rspSh_r <= {rspSh_r[30:0], sdiLvl_r};
            bitCnt_r <= bitCnt_r + 6'h01;
            if (finish)
            begin
              rsp_r <= {rspSh_r[30:0], sdiLvl_r};
              state_r <= HCV_H_IDLE;
            end
          end
        default: state_r <= HCV_H_IDLE;
      endcase
    end
  end

  assign link.bitClk = bitClk_r;
  assign link.sync = sync_r;
  assign link.sdo = sdo_r;
endmodule

// File: tb/hcv_link_props.sv
`timescale 1ns/1ps
module hcv_link_props
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic bitClk,
  input wire logic sync,
  input wire logic sdo,
  input wire logic sdi
);
  // Cycles since the start bit of an answer; the whole answer is 33 bit periods of 8 cycles.
  logic [8:0] rspCnt_r;
  logic sdiPrev_r;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk)
  begin
    sdiPrev_r <= nrst ? sdi : 1'b0;
  end
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rspCnt_r <= 9'h000;
    else if (rspCnt_r != 9'h000)
      rspCnt_r <= (rspCnt_r == 9'h107) ? 9'h000 : rspCnt_r + 9'h001;
    else if (sdi && !sdiPrev_r)
      rspCnt_r <= 9'h001;
  end
  AST_BITCLK_HIGH:
    assert property ($rose(bitClk) |-> bitClk[*4] ##1 !bitClk)
    else $error("Link clock high phase is not four cycles.");
  AST_BITCLK_LOW:
    assert property ($fell(bitClk) |-> !bitClk[*4] ##1 bitClk)
    else $error("Link clock low phase is not four cycles.");
  AST_SYNC_LEN:
    assert property ($rose(sync) |-> sync[*8] ##1 !sync)
    else $error("Frame start is not one bit period long.");
  AST_SYNC_ON_LOW:
    assert property ($rose(sync) |-> !bitClk)
    else $error("Frame start changed while the link clock was high.");
  AST_SDO_ON_LOW:
    assert property (!$stable(sdo) |-> !bitClk)
    else $error("Command line changed while the link clock was high.");
  AST_SDO_QUIET_AT_SYNC:
    assert property (sync |-> !sdo)
    else $error("Command line active during frame start.");
  AST_SDI_HOLD:
    assert property ($changed(sdi) |=> $stable(sdi)[*7])
    else $error("Answer bit held for less than one bit period.");
  AST_SDI_QUIET_AT_SYNC:
    assert property (sync |-> !sdi)
    else $error("Answer line active while a new frame starts.");
  AST_RSP_START:
    assert property ((rspCnt_r >= 9'h001 && rspCnt_r <= 9'h007) |-> sdi)
    else $error("Start bit shorter than one bit period.");
  AST_RSP_UPPER_ZERO:
    assert property ((rspCnt_r >= 9'h008 && rspCnt_r <= 9'h087) |-> !sdi)
    else $error("Answer bits 31 to 16 are not zero.");
  AST_RSP_END:
    assert property (rspCnt_r == 9'h107 |=> !sdi)
    else $error("Answer line not released after 32 data bits.");
endmodule

// File: tb/hda_codec_widget_verb_ctrl_bench.sv
`timescale 1ns/1ps
`include "hcv_defs.svh"
module hda_codec_widget_verb_ctrl_bench;
  import hcv_pkg::*;
  localparam int NROWS = 40;
  localparam logic [3:0] ACMD = {`HCV_REG_CMD, 2'h0};
  localparam logic [3:0] ARSP = {`HCV_REG_RSP, 2'h0};
  localparam logic [3:0] ASTAT = {`HCV_REG_STAT, 2'h0};
  // Each row is a command word and the answer it must produce; order matters, each set precedes the gets that read it back.
  hcv_word_t rows [0:NROWS-1][0:1] = '{
    '{32'h003B8000, 32'h00000080}, '{32'h003B0000, 32'h00000000}, '{32'h007B8000, 32'h00000080},
    '{32'h0033B055, 32'h00000000}, '{32'h003B8000, 32'h00000000}, '{32'h008B2000, 32'h00000080},
    '{32'h008B8000, 32'h00000000}, '{32'h00836025, 32'h00000000}, '{32'h008B2003, 32'h00000025},
    '{32'h008B0000, 32'h00000080}, '{32'h014B8000, 32'h00000000}, '{32'h0143707F, 32'h00000000},
    '{32'h014B2005, 32'h00000000}, '{32'h01CB0000, 32'h00000080}, '{32'h015B2001, 32'h00000080},
    '{32'h01536192, 32'h00000000}, '{32'h015B2001, 32'h00000092}, '{32'h015B2000, 32'h00000080},
    '{32'h0153B0C4, 32'h00000000}, '{32'h015BA000, 32'h000000C4}, '{32'h016B8000, 32'h00000000},
    '{32'h01BB0000, 32'h00000080}, '{32'h023B0000, 32'h00000000}, '{32'h0233A033, 32'h00000000},
    '{32'h023BA000, 32'h00000033}, '{32'h023B8000, 32'h00000080}, '{32'h002B8000, 32'h00000000},
    '{32'h003A0000, 32'h00000011}, '{32'h0042CBB1, 32'h00000000}, '{32'h004A0000, 32'h0000CB31},
    '{32'h0082CBB1, 32'h00000000}, '{32'h008A0000, 32'h0000C831}, '{32'h010A0000, 32'h00000000},
    '{32'h001F0500, 32'h00000000}, '{32'h00170503, 32'h00000000}, '{32'h001F0500, 32'h00000033},
    '{32'h002F0500, 32'h00000000}, '{32'h00870635, 32'h00000000}, '{32'h008F0600, 32'h00000035},
    '{32'h003F0600, 32'h00000000}};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbAdr = 4'h0;
  logic [3:0] wbSel = 4'h0;
  hcv_word_t wbDatW = 32'h00000000;
  hcv_word_t wbDatR;
  logic wbAck;
  hcv_pwr_t powerState;
  logic [3:0] capStream;
  logic [3:0] capLeft;
  logic [3:0] capRight;
  hcv_word_t rd;
  int numErrors = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #25 mclk = ~mclk;
  hcv_link_if link();
  hcv_codec i_hcv_codec(.mclk(mclk), .nrst(nrst), .link(link.codec), .powerState(powerState),
    .captureStream(capStream), .captureLeftChan(capLeft), .captureRightChan(capRight));
  hcv_host i_hcv_host(.mclk(mclk), .nrst(nrst), .link(link.host), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
  hcv_link_props i_hcv_link_props(.mclk(mclk), .nrst(nrst), .bitClk(link.bitClk), .sync(link.sync),
    .sdo(link.sdo), .sdi(link.sdi));
  task automatic endSim;
    if (numErrors == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input hcv_word_t seen, input hcv_word_t exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; returns one edge after the ack so the bus idles a cycle.
  task automatic wbXfer(input logic we, input logic [3:0] adr, input hcv_word_t dat, output hcv_word_t data);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatW <= dat;
    @(posedge mclk);
    while (wbAck !== 1'b1)
      @(posedge mclk);
    data = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic waitRsp(output hcv_word_t rsp);
    hcv_word_t st;
    do
      wbXfer(1'b0, ASTAT, 32'h00000000, st);
    while (st[`HCV_STAT_DONE_BIT] !== 1'b1);
    wbXfer(1'b0, ARSP, 32'h00000000, rsp);
    wbXfer(1'b1, ASTAT, 32'h00000002, st);
  endtask
  task automatic runCmd(input hcv_word_t cmd, output hcv_word_t rsp);
    hcv_word_t st;
    wbXfer(1'b1, ACMD, cmd, st);
    waitRsp(rsp);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      numErrors++;
      endSim();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    check({14'h0, link.bitClk, link.sync, link.sdo, link.sdi, capStream, capLeft, capRight, powerState}, 32'h0);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < NROWS; i++)
    begin
      runCmd(rows[i][0], rd);
      check(rd, rows[i][1]);
    end
    check({18'h0, powerState, capStream, capLeft, capRight}, 32'h00003356);
    runCmd(32'h0087061F, rd);
    check({24'h0, capLeft, capRight}, 32'h000000F0);
    wbXfer(1'b1, ACMD, 32'h001F0500, rd);
    wbXfer(1'b0, ASTAT, 32'h00000000, rd);
    check(rd & 32'h00000001, 32'h00000001);
    wbXfer(1'b1, ACMD, 32'h00170501, rd);
    waitRsp(rd);
    check(rd, 32'h00000033);
    check({30'h0, powerState}, 32'h00000003);
    wbXfer(1'b0, ACMD, 32'h00000000, rd);
    check(rd, 32'h001F0500);
    wbXfer(1'b1, ARSP, 32'hFFFFFFFF, rd);
    wbXfer(1'b0, ARSP, 32'h00000000, rd);
    check(rd, 32'h00000033);
    wbXfer(1'b0, 4'hC, 32'h00000000, rd);
    check(rd, 32'h00000000);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    check({18'h0, powerState, capStream, capLeft, capRight}, 32'h0);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    runCmd(32'h008B2000, rd);
    check(rd, 32'h00000080);
    runCmd(32'h004A0000, rd);
    check(rd, 32'h00000011);
    endSim();
  end
endmodule
